// ---- rtl/afr_pkg.sv ----
// Package: register map, field layout and decode helpers for the analog config bank
package afr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  localparam logic [5:0] OFS_MAIN_CFG   = 6'h00;
  localparam logic [5:0] OFS_PWR_DOWN   = 6'h01;
  localparam logic [5:0] OFS_GAIN_TRIM  = 6'h02;
  localparam logic [5:0] OFS_CONV_TRIM  = 6'h03;

  localparam logic [7:0] RST_MAIN_CFG   = 8'h04;
  localparam logic [7:0] RST_PWR_DOWN   = 8'h00;
  localparam logic [7:0] RST_GAIN_TRIM  = 8'h24;
  localparam logic [7:0] RST_CONV_TRIM  = 8'h5B;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned MC_CDS_BIT    = 0;
  localparam int unsigned MC_GAIN_BIT   = 2;
  localparam int unsigned MC_GATE_BIT   = 3;
  localparam int unsigned MC_FINE_BIT   = 5;
  localparam int unsigned MC_COARSE_BIT = 6;
  // Writable bits of main config: 6,5,3,2,0 (bit 4 and 1 reserved, 7 unused)
  localparam logic [7:0] MC_WR_MASK    = 8'h6D;

  localparam int unsigned PD_CONV1_BIT  = 0;
  localparam int unsigned PD_CONV2_BIT  = 1;
  localparam int unsigned PD_PGA1_BIT   = 2;
  localparam int unsigned PD_PGA2_BIT   = 3;
  localparam int unsigned PD_REF1_BIT   = 4;
  localparam int unsigned PD_REF2_BIT   = 5;
  localparam int unsigned PD_CLPV_BIT   = 6;
  localparam int unsigned PD_MASTER_BIT = 7;

  localparam int unsigned TRIM_LO_LSB   = 0;
  localparam int unsigned TRIM_HI_LSB   = 3;
  localparam int unsigned TRIM_W        = 3;
  localparam logic [7:0] GT_WR_MASK    = 8'h3F;
  localparam logic [7:0] CT_WR_MASK    = 8'hFF;

  // Non-binary converter power codes
  localparam logic [2:0] CT_CODE_25  = 3'h0;
  localparam logic [2:0] CT_CODE_50  = 3'h1;
  localparam logic [2:0] CT_CODE_75  = 3'h3;
  localparam logic [2:0] CT_CODE_100 = 3'h7;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    AFR_PWR_25  = 4'h1,
    AFR_PWR_50  = 4'h2,
    AFR_PWR_75  = 4'h4,
    AFR_PWR_100 = 4'h8
  } afr_pwr_level_e;

  typedef struct packed {
    logic       cds_en;
    logic       double_gain;
    logic       clamp_gate_en;
    logic       fine_dac_en;
    logic       coarse_dac_en;
  } afr_front_cfg_s;

  typedef struct packed {
    logic       clamp_buf_pd;
    logic [1:0] ref_buf_pd;
    logic [1:0] pga_pd;
    logic [1:0] conv_pd;
  } afr_power_s;

  typedef struct packed {
    logic [2:0]     pga_stage1_bias;
    logic [2:0]     pga_stage2_bias;
    afr_pwr_level_e conv_level2;
    afr_pwr_level_e conv_level1;
    logic           conv_code_bad;
  } afr_trim_s;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Map a converter trim code onto a power level; unknown codes fall to 100%
  function automatic afr_pwr_level_e conv_level(input logic [2:0] code);
    afr_pwr_level_e lvl;
    case (code)
      CT_CODE_25:  lvl = AFR_PWR_25;
      CT_CODE_50:  lvl = AFR_PWR_50;
      CT_CODE_75:  lvl = AFR_PWR_75;
      default:     lvl = AFR_PWR_100;
    endcase
    return lvl;
  endfunction : conv_level

  function automatic logic conv_code_ok(input logic [2:0] code);
    return (code == CT_CODE_25) || (code == CT_CODE_50) ||
           (code == CT_CODE_75) || (code == CT_CODE_100);
  endfunction : conv_code_ok

endpackage : afr_pkg

// ---- rtl/afr_cfg_reg.sv ----
// Single 8-bit configuration register with write mask and reset value
`timescale 1ns/1ns
module afr_cfg_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // Write side
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  // Stored value
  output logic      [7:0] value_o
);

  logic [7:0] value_d;
  logic [7:0] value_q;

  // Masked bits keep their reset value, so unused bits never move
  always_comb begin
    value_d = value_q;
    if (wr_en_i) begin
      value_d = (wr_data_i & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

  // Register stage
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

endmodule : afr_cfg_reg

// ---- rtl/afr_clamp_gate.sv ----
// Clamp gating path: passes or ANDs the external clamp with the clamp window
`timescale 1ns/1ns
module afr_clamp_gate (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // Control
  input  wire logic gate_en_i,
  // Clamp sources
  input  wire logic ext_clamp_input_i,
  input  wire logic clamp_window_i,
  // Effective clamp
  output logic      clamp_o
);

  logic clamp_d;
  logic clamp_q;

  // Gated or plain clamp, registered to keep the output glitch free
  always_comb begin
    if (gate_en_i) begin
      clamp_d = ext_clamp_input_i & clamp_window_i;
    end else begin
      clamp_d = ext_clamp_input_i;
    end
  end

  // Register stage
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      clamp_q <= 1'b0;
    end else begin
      clamp_q <= clamp_d;
    end
  end

  assign clamp_o = clamp_q;

endmodule : afr_clamp_gate

// ---- rtl/afr_analog_cfg_regs.sv ----
// Analog configuration register bank: four registers and their decoded controls
// Contract
// RL1: Host loads baseline values after power-up
// RL2: Main bit 3 gates clamp with window
// RL3: Main bit 2 selects unity or double gain
// RL4: Main bit 0 enables correlated double sampling
// RL5: Main bits 6,5 enable coarse, fine DAC
// RL6: Power-down bit 7 overrides all lower bits
// RL7: Power-down bit 6 powers down clamp buffer
// RL8: Power-down bits 5,4 reference buffers
// RL9: Power-down bits 3,2 gain amplifiers
// RL10: Power-down bits 1,0 converters
// RL11: Gain trim bits 5:3 stage one bias
// RL12: Gain trim bits 2:0 stage two bias
// RL13: Converter trim bits 5:3 non-binary level
// RL14: Converter trim bits 2:0 non-binary level
// RL15: Host writes 01 into converter trim 7:6
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
module afr_analog_cfg_regs (
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        reset_i,
  // Register port
  input  wire logic [afr_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [afr_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [afr_pkg::DATA_W-1:0]  reg_rdata_o,
  // Clamp sources
  input  wire logic                        ext_clamp_input_i,
  input  wire logic                        clamp_window_i,
  // Analog controls
  output logic                             clamp_o,
  output afr_pkg::afr_front_cfg_s          front_cfg_o,
  output logic                             master_pd_o,
  output afr_pkg::afr_power_s              power_o,
  output afr_pkg::afr_trim_s               trim_o
);

  // ************************************************************
  // Address decode
  // ************************************************************
  logic       wr_main;
  logic       wr_pd;
  logic       wr_gt;
  logic       wr_ct;
  logic [7:0] main_val;
  logic [7:0] pd_val;
  logic [7:0] gt_val;
  logic [7:0] ct_val;

  // One write enable per register; unmapped writes are dropped
  always_comb begin
    wr_main = reg_wr_i && (reg_addr_i == afr_pkg::OFS_MAIN_CFG);
    wr_pd   = reg_wr_i && (reg_addr_i == afr_pkg::OFS_PWR_DOWN);
    wr_gt   = reg_wr_i && (reg_addr_i == afr_pkg::OFS_GAIN_TRIM);
    wr_ct   = reg_wr_i && (reg_addr_i == afr_pkg::OFS_CONV_TRIM);
  end

  // ************************************************************
  // Storage
  // ************************************************************
  // Reset loads the baseline, so the bank is valid even before the host loads it
  afr_cfg_reg #(
    .RESET_VAL (afr_pkg::RST_MAIN_CFG),
    .WR_MASK   (afr_pkg::MC_WR_MASK)
  ) u_main (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (wr_main),
    .wr_data_i  (reg_wdata_i),
    .value_o    (main_val)
  ); // RL1 RL5

  afr_cfg_reg #(
    .RESET_VAL (afr_pkg::RST_PWR_DOWN),
    .WR_MASK   (8'hFF)
  ) u_pd (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (wr_pd),
    .wr_data_i  (reg_wdata_i),
    .value_o    (pd_val)
  );

  afr_cfg_reg #(
    .RESET_VAL (afr_pkg::RST_GAIN_TRIM),
    .WR_MASK   (afr_pkg::GT_WR_MASK)
  ) u_gt (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (wr_gt),
    .wr_data_i  (reg_wdata_i),
    .value_o    (gt_val)
  ); // RL12

  // Reserved top bits are stored as written; the host is trusted to write 01
  afr_cfg_reg #(
    .RESET_VAL (afr_pkg::RST_CONV_TRIM),
    .WR_MASK   (afr_pkg::CT_WR_MASK)
  ) u_ct (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (wr_ct),
    .wr_data_i  (reg_wdata_i),
    .value_o    (ct_val)
  ); // RL15

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // Data valid only in the cycle after the strobe; zero otherwise
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        afr_pkg::OFS_MAIN_CFG:  rdata_d = main_val;
        afr_pkg::OFS_PWR_DOWN:  rdata_d = pd_val;
        afr_pkg::OFS_GAIN_TRIM: rdata_d = gt_val;
        afr_pkg::OFS_CONV_TRIM: rdata_d = ct_val;
        default:                rdata_d = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Decoded analog controls
  // ************************************************************
  afr_pkg::afr_front_cfg_s front_d;
  afr_pkg::afr_front_cfg_s front_q;
  afr_pkg::afr_power_s     power_d;
  afr_pkg::afr_power_s     power_q;
  afr_pkg::afr_trim_s      trim_d;
  afr_pkg::afr_trim_s      trim_q;
  logic                    master_d;
  logic                    master_q;

  // Front-end mode bits
  always_comb begin
    front_d.cds_en        = main_val[afr_pkg::MC_CDS_BIT];    // RL4
    front_d.double_gain   = main_val[afr_pkg::MC_GAIN_BIT];   // RL3
    front_d.clamp_gate_en = main_val[afr_pkg::MC_GATE_BIT];   // RL2
    front_d.fine_dac_en   = main_val[afr_pkg::MC_FINE_BIT];   // RL5
    front_d.coarse_dac_en = main_val[afr_pkg::MC_COARSE_BIT]; // RL5
  end

  // Master power-down forces every block down, whatever the lower bits hold
  always_comb begin
    master_d              = pd_val[afr_pkg::PD_MASTER_BIT]; // RL6
    power_d.clamp_buf_pd  = master_d | pd_val[afr_pkg::PD_CLPV_BIT];  // RL7
    power_d.ref_buf_pd[1] = master_d | pd_val[afr_pkg::PD_REF2_BIT];  // RL8
    power_d.ref_buf_pd[0] = master_d | pd_val[afr_pkg::PD_REF1_BIT];  // RL8
    power_d.pga_pd[1]     = master_d | pd_val[afr_pkg::PD_PGA2_BIT];  // RL9
    power_d.pga_pd[0]     = master_d | pd_val[afr_pkg::PD_PGA1_BIT];  // RL9
    power_d.conv_pd[1]    = master_d | pd_val[afr_pkg::PD_CONV2_BIT]; // RL10
    power_d.conv_pd[0]    = master_d | pd_val[afr_pkg::PD_CONV1_BIT]; // RL10
  end

  // Trim fields; converter codes decoded since they are not binary weighted
  always_comb begin
    trim_d.pga_stage1_bias = gt_val[afr_pkg::TRIM_HI_LSB +: afr_pkg::TRIM_W]; // RL11
    trim_d.pga_stage2_bias = gt_val[afr_pkg::TRIM_LO_LSB +: afr_pkg::TRIM_W]; // RL12
    trim_d.conv_level2     = afr_pkg::conv_level(ct_val[afr_pkg::TRIM_HI_LSB +: afr_pkg::TRIM_W]); // RL13
    trim_d.conv_level1     = afr_pkg::conv_level(ct_val[afr_pkg::TRIM_LO_LSB +: afr_pkg::TRIM_W]); // RL14
    trim_d.conv_code_bad   = !afr_pkg::conv_code_ok(ct_val[afr_pkg::TRIM_HI_LSB +: afr_pkg::TRIM_W]) ||
                             !afr_pkg::conv_code_ok(ct_val[afr_pkg::TRIM_LO_LSB +: afr_pkg::TRIM_W]);
  end

  // Output register stage; controls follow a write by two edges
  // Reset values mirror the decoded register baselines, so nothing jumps on release
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_q  <= 8'h00;
      front_q  <= '{cds_en:        afr_pkg::RST_MAIN_CFG[afr_pkg::MC_CDS_BIT],
                    double_gain:   afr_pkg::RST_MAIN_CFG[afr_pkg::MC_GAIN_BIT],
                    clamp_gate_en: afr_pkg::RST_MAIN_CFG[afr_pkg::MC_GATE_BIT],
                    fine_dac_en:   afr_pkg::RST_MAIN_CFG[afr_pkg::MC_FINE_BIT],
                    coarse_dac_en: afr_pkg::RST_MAIN_CFG[afr_pkg::MC_COARSE_BIT]};
      power_q  <= '0;
      master_q <= 1'b0;
      trim_q   <= '{pga_stage1_bias: afr_pkg::RST_GAIN_TRIM[afr_pkg::TRIM_HI_LSB +: afr_pkg::TRIM_W],
                    pga_stage2_bias: afr_pkg::RST_GAIN_TRIM[afr_pkg::TRIM_LO_LSB +: afr_pkg::TRIM_W],
                    conv_level2:     afr_pkg::AFR_PWR_75,
                    conv_level1:     afr_pkg::AFR_PWR_75,
                    conv_code_bad:   1'b0}; // RL13 RL14
    end else begin
      rdata_q  <= rdata_d;
      front_q  <= front_d;
      power_q  <= power_d;
      master_q <= master_d;
      trim_q   <= trim_d;
    end
  end

  // ************************************************************
  // Clamp path
  // ************************************************************
  afr_clamp_gate u_clamp (
    .core_clk_i        (core_clk_i),
    .reset_i           (reset_i),
    .gate_en_i         (main_val[afr_pkg::MC_GATE_BIT]),
    .ext_clamp_input_i (ext_clamp_input_i),
    .clamp_window_i    (clamp_window_i),
    .clamp_o           (clamp_o)
  ); // RL2

  assign reg_rdata_o = rdata_q;
  assign front_cfg_o = front_q;
  assign power_o     = power_q;
  assign master_pd_o = master_q;
  assign trim_o      = trim_q;

endmodule : afr_analog_cfg_regs

// ---- tb/afr_analog_cfg_regs_assertions.sv ----
// Checker: port-level properties of the analog config bank
`timescale 1ns/1ns
module afr_cfg_chk (
  // Clock and reset
  input wire logic                       core_clk_i,
  input wire logic                       reset_i,
  // Register port
  input wire logic [afr_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [afr_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [afr_pkg::DATA_W-1:0] reg_rdata_o,
  // Clamp and decoded controls
  input wire logic                       ext_clamp_input_i,
  input wire logic                       clamp_window_i,
  input wire logic                       clamp_o,
  input wire afr_pkg::afr_front_cfg_s    front_cfg_o,
  input wire logic                       master_pd_o,
  input wire afr_pkg::afr_power_s        power_o,
  input wire afr_pkg::afr_trim_s         trim_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] w1_q;
  logic [7:0] w2_q;
  // Write data delayed to line up with decoded outputs
  always_ff @(posedge core_clk_i) begin
    w1_q <= reg_wdata_i;
    w2_q <= w1_q;
  end
  // Own table of power codes, kept apart from the design's helper
  function automatic logic [3:0] lvl(input logic [2:0] c);
    return (c == 3'h0) ? 4'h1 : (c == 3'h1) ? 4'h2 : (c == 3'h3) ? 4'h4 : 4'h8;
  endfunction : lvl
  sequence s_wr(logic [5:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_quiet;
    (!reg_wr_i)[*2];
  endsequence
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  property p_front;
    s_wr(afr_pkg::OFS_MAIN_CFG) |-> ##2 front_cfg_o == {w2_q[0], w2_q[2], w2_q[3], w2_q[5], w2_q[6]};
  endproperty
  property p_master;
    s_wr(afr_pkg::OFS_PWR_DOWN) |-> ##2 master_pd_o == w2_q[7];
  endproperty
  property p_pd_bits;
    s_wr(afr_pkg::OFS_PWR_DOWN) ##2 !master_pd_o |-> power_o == w2_q[6:0];
  endproperty
  property p_override;
    master_pd_o |-> power_o == 7'h7F;
  endproperty
  property p_gain;
    s_wr(afr_pkg::OFS_GAIN_TRIM) |-> ##2 {trim_o.pga_stage1_bias, trim_o.pga_stage2_bias} == w2_q[5:0];
  endproperty
  property p_conv;
    s_wr(afr_pkg::OFS_CONV_TRIM) |-> ##2 trim_o.conv_level2 == lvl(w2_q[5:3]) && trim_o.conv_level1 == lvl(w2_q[2:0]);
  endproperty
  property p_clamp;
    !$past(reset_i) && front_cfg_o.clamp_gate_en == $past(front_cfg_o.clamp_gate_en)
      && front_cfg_o.clamp_gate_en == $past(front_cfg_o.clamp_gate_en, 2)
      |-> clamp_o == ($past(ext_clamp_input_i) & ($past(clamp_window_i) | !front_cfg_o.clamp_gate_en));
  endproperty
  property p_hold;
    s_quiet |=> $stable(front_cfg_o) && $stable(power_o) && $stable(trim_o);
  endproperty
  a_rd_idle:  assert property (p_rd_idle)  else $error("read data not idle");
  a_front:    assert property (p_front)    else $error("front config mismatch");
  a_master:   assert property (p_master)   else $error("master power-down mismatch");
  a_pd_bits:  assert property (p_pd_bits)  else $error("block power-down mismatch");
  a_override: assert property (p_override) else $error("master does not override");
  a_gain:     assert property (p_gain)     else $error("gain trim mismatch");
  a_conv:     assert property (p_conv)     else $error("converter level mismatch");
  a_clamp:    assert property (p_clamp)    else $error("clamp output mismatch");
  a_hold:     assert property (p_hold)     else $error("controls moved without write");
endmodule : afr_cfg_chk
bind afr_analog_cfg_regs afr_cfg_chk u_chk (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .ext_clamp_input_i, .clamp_window_i, .clamp_o, .front_cfg_o, .master_pd_o,
  .power_o, .trim_o);

// ---- tb/afr_analog_cfg_regs_tb.sv ----
// Testbench: self-checking scenarios for the analog config bank
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module afr_analog_cfg_regs_tb;
  logic                    core_clk_i = 1'b0;
  logic                    reset_i = 1'b1;
  logic [5:0]              reg_addr_i = 6'h00;
  logic [7:0]              reg_wdata_i = 8'h00;
  logic                    reg_wr_i = 1'b0;
  logic                    reg_rd_i = 1'b0;
  logic [7:0]              reg_rdata_o;
  logic                    ext_clamp_input_i = 1'b0;
  logic                    clamp_window_i = 1'b0;
  logic                    clamp_o;
  afr_pkg::afr_front_cfg_s front_cfg_o;
  logic                    master_pd_o;
  afr_pkg::afr_power_s     power_o;
  afr_pkg::afr_trim_s      trim_o;
  int                      fail_count = 0;
  int                      check_count = 0;
  int                      cyc = 0;
  afr_analog_cfg_regs dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ext_clamp_input_i(ext_clamp_input_i), .clamp_window_i(clamp_window_i), .clamp_o(clamp_o),
    .front_cfg_o(front_cfg_o), .master_pd_o(master_pd_o), .power_o(power_o), .trim_o(trim_o));
  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  // Whole run needs about a hundred cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // ****************************************
  // Bus helpers
  // ****************************************
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask : rd
  // Decoded outputs trail the write by two edges
  task automatic settle();
    @(posedge core_clk_i);
    #1;
  endtask : settle
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(afr_pkg::OFS_MAIN_CFG, 8'h04);
    rd(afr_pkg::OFS_PWR_DOWN, 8'h00);
    rd(afr_pkg::OFS_GAIN_TRIM, 8'h24);
    rd(afr_pkg::OFS_CONV_TRIM, 8'h5B);
    rd(6'h04, 8'h00);
    `CHK(front_cfg_o, 5'b01000)
    `CHK(master_pd_o, 1'b0)
    `CHK(power_o, 7'h00)
    `CHK({trim_o.pga_stage1_bias, trim_o.pga_stage2_bias}, 6'o44)
    `CHK(trim_o.conv_level2, 4'h4)
    `CHK(trim_o.conv_level1, 4'h4)
    `CHK(trim_o.conv_code_bad, 1'b0)
  endtask : t_reset
  task automatic t_main();
    wr(afr_pkg::OFS_MAIN_CFG, 8'hFF);
    rd(afr_pkg::OFS_MAIN_CFG, 8'h6D);
    wr(afr_pkg::OFS_MAIN_CFG, 8'h41);
    settle();
    `CHK(front_cfg_o, 5'b10001)
    wr(afr_pkg::OFS_MAIN_CFG, 8'h2C);
    settle();
    `CHK(front_cfg_o, 5'b01110)
  endtask : t_main
  task automatic t_power();
    logic [7:0] d[5] = '{8'h7F, 8'h80, 8'h95, 8'h2A, 8'h55};
    for (int i = 0; i < 5; i++) begin
      wr(afr_pkg::OFS_PWR_DOWN, d[i]);
      settle();
      `CHK(master_pd_o, d[i][7])
      `CHK(power_o, d[i][7] ? 7'h7F : d[i][6:0])
    end
  endtask : t_power
  task automatic t_trim();
    logic [2:0] c[5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
    logic [3:0] l[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8};
    wr(afr_pkg::OFS_GAIN_TRIM, 8'hFF);
    rd(afr_pkg::OFS_GAIN_TRIM, 8'h3F);
    wr(afr_pkg::OFS_GAIN_TRIM, 8'h1C);
    settle();
    `CHK({trim_o.pga_stage1_bias, trim_o.pga_stage2_bias}, 6'o34)
    for (int i = 0; i < 5; i++) begin
      wr(afr_pkg::OFS_CONV_TRIM, {2'b01, c[i], c[(i + 1) % 5]});
      settle();
      `CHK(trim_o.conv_level2, l[i])
      `CHK(trim_o.conv_level1, l[(i + 1) % 5])
      `CHK(trim_o.conv_code_bad, (c[i] == 3'h2) || (c[(i + 1) % 5] == 3'h2))
    end
    rd(afr_pkg::OFS_CONV_TRIM, 8'h50);
  endtask : t_trim
  task automatic t_clamp();
    for (int g = 0; g < 2; g++) begin
      wr(afr_pkg::OFS_MAIN_CFG, g ? 8'h08 : 8'h00);
      settle();
      for (int k = 0; k < 4; k++) begin
        @(posedge core_clk_i);
        ext_clamp_input_i <= k[1];
        clamp_window_i <= k[0];
        settle();
        `CHK(clamp_o, g ? (k[1] & k[0]) : k[1])
      end
    end
  endtask : t_clamp
  // Write then read at once, plus an ignored unmapped write
  task automatic t_b2b();
    @(posedge core_clk_i);
    reg_addr_i <= afr_pkg::OFS_PWR_DOWN;
    reg_wdata_i <= 8'h3C;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(reg_rdata_o, 8'h3C)
    wr(6'h05, 8'hFF);
    rd(afr_pkg::OFS_PWR_DOWN, 8'h3C);
  endtask : t_b2b
  initial begin
    t_reset();
    t_main();
    t_power();
    t_trim();
    t_clamp();
    t_b2b();
    t_reset();
    finish_test();
  end
endmodule : afr_analog_cfg_regs_tb
